// ==== hdl/pmr_pkg.sv ====
package pmr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CONFIG = 6'h00;
    localparam logic [5:0] IDX_SHUNT = 6'h01;
    localparam logic [5:0] IDX_BUS = 6'h02;
    localparam logic [5:0] IDX_POWER = 6'h03;
    localparam logic [5:0] IDX_CURRENT = 6'h04;
    localparam logic [5:0] IDX_CAL = 6'h05;
    localparam logic [5:0] IDX_STATUS = 6'h06;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 7;

    ////////////////////////////////////////////////////////////////////////
    // Configuration fields
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam int MODE_SHUNT_BIT = 0;
    localparam int MODE_BUS_BIT = 1;
    localparam int MODE_CONT_BIT = 2;
    localparam int AVG_LSB = 9;
    localparam int AVG_W = 3;
    localparam logic [15:0] CFG_RESET = 16'h0007;
    localparam logic [15:0] CFG_WR_MASK = 16'h0E07;
    localparam logic [15:0] CAL_RESET = 16'h0000;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Status fields
    localparam int STAT_READY_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;

    ////////////////////////////////////////////////////////////////////////
    // Arithmetic scaling
    localparam int CURRENT_SHIFT = 11;
    localparam logic [31:0] POWER_DIV = 32'h00004E20;
    localparam logic [15:0] BUS_MAG_MASK = 16'h7FFF;
    localparam logic [15:0] POS_MAX = 16'h7FFF;
    localparam logic [15:0] NEG_MIN = 16'h8000;
    localparam logic [15:0] UNS_MAX = 16'hFFFF;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0]
    {
        CALC_IDLE = 2'b00,
        CALC_CURRENT = 2'b01,
        CALC_POWER = 2'b10
    } pmr_calc_t;

    typedef struct packed
    {
        logic valid;
        logic is_bus;
        logic [15:0] data;
    } pmr_sample_t;

    typedef struct packed
    {
        logic request;
        logic shunt_en;
        logic bus_en;
        logic continuous;
    } pmr_conv_ctrl_t;

endpackage

// ==== hdl/pmr_average.sv ====
`timescale 1ns/1ns
module pmr_average
    import pmr_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic clear,
    input wire logic [AVG_W-1:0] avg_sel,
    // Samples in
    input wire logic in_valid,
    input wire logic [15:0] in_data,
    // Averaged result
    output logic out_valid,
    output logic [15:0] out_data
);

    logic signed [25:0] acc_r;
    logic signed [25:0] acc_nxt;
    logic [10:0] cnt_r;
    logic [10:0] cnt_nxt;
    logic out_valid_r;
    logic [15:0] out_data_r;
    logic [3:0] shift;
    logic [10:0] target;
    logic last;
    logic signed [25:0] mean;

    // Averaging counts 1,4,16,64,128,256,512,1024 as shifts
    function automatic logic [3:0] avg_shift(input logic [AVG_W-1:0] sel);
        logic [3:0] s;
        s = (sel < 3'h4) ? {sel, 1'b0} : 4'({1'b0, sel} + 4'h3);
        return s;
    endfunction

    assign shift = avg_shift(avg_sel);
    assign target = 11'(11'h001 << shift) - 11'h001;
    assign last = in_valid && (cnt_r == target);
    assign acc_nxt = acc_r + 26'(signed'(in_data));
    assign mean = acc_nxt >>> shift;
    assign cnt_nxt = last ? 11'h000 : 11'(cnt_r + 11'h001);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc_r <= '0;
            cnt_r <= '0;
            out_valid_r <= 1'b0;
            out_data_r <= 16'h0000;
        end
        else
        begin
            out_valid_r <= last && !clear;
            if (clear)
            begin
                acc_r <= '0;
                cnt_r <= '0;
            end
            else if (in_valid)
            begin
                acc_r <= last ? '0 : acc_nxt;
                cnt_r <= cnt_nxt;
                if (last)
                    out_data_r <= mean[15:0];
            end
        end
    end

    assign out_valid = out_valid_r;
    assign out_data = out_data_r;

endmodule

// ==== hdl/pmr_result_regs.sv ====
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// Function
// - Mode bit two set repeats measurements; clear runs one triggered conversion.
// - Mode bits one and zero enable bus and shunt; both clear powers down.
// - Shunt result is a signed two's-complement word, bit fifteen the sign.
// - Shunt result counts 2.5 microvolts each; 7FFF is full scale.
// - Bus result counts 1.25 millivolts each; 7FFF is full scale.
// - Bus result top bit always reads zero.
// - With averaging on, shunt and bus results load the averaged value.
// - Shunt and bus results hold the latest reading, replaced on completion.
// - One power count weighs 25 current steps.
// - Power comes from current result times bus result.
// - Current comes from shunt result times calibration value.
// - Calibration is read/write and sets current and power step size.
// - Mode field resets to continuous shunt and bus measurement.
module pmr_result_regs
    import pmr_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Converter side
    input wire pmr_sample_t sample,
    output pmr_conv_ctrl_t conv_ctrl
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [15:0] cfg_r;
    logic [15:0] cfg_nxt;
    logic [15:0] cal_r;
    logic [15:0] cal_nxt;
    logic [15:0] shunt_r;
    logic [15:0] bus_r;
    logic [15:0] current_r;
    logic [15:0] power_r;
    logic ready_r;
    logic ready_nxt;
    logic wr_pend_r;
    logic [5:0] wr_idx_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;
    pmr_calc_t calc_r;
    pmr_calc_t calc_nxt;
    logic calc_again_r;
    pmr_conv_ctrl_t ctrl_r;
    pmr_conv_ctrl_t ctrl_nxt;
    logic shunt_got_r;
    logic bus_got_r;

    logic accept;
    logic rd_accept;
    logic [5:0] a_idx;
    logic a_mapped;
    logic [31:0] rd_word;
    logic cfg_wr;
    logic cal_wr;
    logic stat_rd;
    logic [2:0] mode_nxt;
    logic shunt_en_nxt;
    logic bus_en_nxt;
    logic cont_nxt;
    logic pdown_nxt;
    logic shunt_in;
    logic bus_in;
    logic shunt_avg_valid;
    logic bus_avg_valid;
    logic [15:0] shunt_avg;
    logic [15:0] bus_avg;
    logic new_result;
    logic trig_done;

    ////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic [15:0] sat_signed(input logic signed [32:0] v);
        logic [15:0] r;
        if (v > 33'sd32767)
            r = POS_MAX;
        else if (v < -33'sd32768)
            r = NEG_MIN;
        else
            r = v[15:0];
        return r;
    endfunction

    // Current = shunt * calibration / 2048, signed result
    function automatic logic [15:0] calc_current(input logic [15:0] shunt,
                                                 input logic [15:0] cal);
        logic signed [32:0] prod;
        prod = 33'(signed'(shunt)) * 33'(signed'({1'b0, cal}));
        return sat_signed(prod >>> CURRENT_SHIFT);
    endfunction

    // Power = |current| * bus / 20000, which makes one count 25 current steps
    function automatic logic [15:0] calc_power(input logic [15:0] cur,
                                               input logic [15:0] bus);
        logic [16:0] mag;
        logic [31:0] prod;
        logic [31:0] quo;
        logic [15:0] r;
        mag = cur[15] ? 17'(17'h00000 - {cur[15], cur}) : {1'b0, cur};
        prod = 32'(mag) * 32'(bus & BUS_MAG_MASK);
        quo = prod / POWER_DIV;
        r = (quo > 32'(UNS_MAX)) ? UNS_MAX : quo[15:0];
        return r;
    endfunction

    function automatic logic [5:0] byte_to_idx(input logic [31:0] a);
        return a[IDX_MSB:IDX_LSB];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus address phase decode
    assign accept = hsel && hready && htrans[1];
    assign rd_accept = accept && !hwrite;
    assign a_idx = byte_to_idx(haddr);
    assign a_mapped = (haddr[31:IDX_MSB+1] == '0) && (haddr[1:0] == 2'h0)
                      && (a_idx <= IDX_STATUS);

    // Data phase writes; only config and calibration take data
    assign cfg_wr = wr_pend_r && (wr_idx_r == IDX_CONFIG);
    assign cal_wr = wr_pend_r && (wr_idx_r == IDX_CAL);
    assign cfg_nxt = cfg_wr ? (hwdata[15:0] & CFG_WR_MASK) : cfg_r;
    assign cal_nxt = cal_wr ? hwdata[15:0] : cal_r;
    assign stat_rd = rd_accept && a_mapped && (a_idx == IDX_STATUS);

    // Read mux sees a write that is in its data phase at the same edge
    always_comb
    begin
        rd_word = 32'h00000000;
        if (a_mapped)
        begin
            case (a_idx)
                IDX_CONFIG: rd_word = {16'h0000, cfg_nxt};
                IDX_SHUNT: rd_word = {16'h0000, shunt_r};
                IDX_BUS: rd_word = {16'h0000, 1'b0, bus_r[14:0]};
                IDX_POWER: rd_word = {16'h0000, power_r};
                IDX_CURRENT: rd_word = {16'h0000, current_r};
                IDX_CAL: rd_word = {16'h0000, cal_nxt};
                IDX_STATUS: rd_word = {30'h00000000, calc_r != CALC_IDLE, ready_r};
                default: rd_word = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Operating mode decode
    assign mode_nxt = cfg_nxt[MODE_LSB +: MODE_W];
    assign shunt_en_nxt = mode_nxt[MODE_SHUNT_BIT];
    assign bus_en_nxt = mode_nxt[MODE_BUS_BIT];
    assign pdown_nxt = !shunt_en_nxt && !bus_en_nxt;
    assign cont_nxt = mode_nxt[MODE_CONT_BIT] && !pdown_nxt;

    // A triggered run ends once every enabled measurement has a result
    assign trig_done = !ctrl_r.continuous && ctrl_r.request
                       && (!ctrl_r.shunt_en || shunt_got_r || shunt_avg_valid)
                       && (!ctrl_r.bus_en || bus_got_r || bus_avg_valid);

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        ctrl_nxt.shunt_en = shunt_en_nxt;
        ctrl_nxt.bus_en = bus_en_nxt;
        ctrl_nxt.continuous = cont_nxt;
        if (pdown_nxt)
            ctrl_nxt.request = 1'b0;
        else if (cont_nxt)
            ctrl_nxt.request = 1'b1;
        else if (cfg_wr)
            ctrl_nxt.request = 1'b1;
        else if (trig_done)
            ctrl_nxt.request = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Averaging of incoming conversions
    assign shunt_in = sample.valid && !sample.is_bus && ctrl_r.shunt_en && ctrl_r.request;
    assign bus_in = sample.valid && sample.is_bus && ctrl_r.bus_en && ctrl_r.request;

    pmr_average u_shunt_avg
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(cfg_wr),
        .avg_sel(cfg_r[AVG_LSB +: AVG_W]),
        .in_valid(shunt_in),
        .in_data(sample.data),
        .out_valid(shunt_avg_valid),
        .out_data(shunt_avg)
    );

    pmr_average u_bus_avg
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .clear(cfg_wr),
        .avg_sel(cfg_r[AVG_LSB +: AVG_W]),
        .in_valid(bus_in),
        .in_data(sample.data & BUS_MAG_MASK),
        .out_valid(bus_avg_valid),
        .out_data(bus_avg)
    );

    ////////////////////////////////////////////////////////////////////////
    // Derived result sequencing: current first, then power
    // A result landing during the current step earns one more pass, so fast samples never starve power
    assign new_result = shunt_avg_valid || bus_avg_valid;

    always_comb
    begin
        calc_nxt = calc_r;
        case (calc_r)
            CALC_IDLE: calc_nxt = new_result ? CALC_CURRENT : CALC_IDLE;
            CALC_CURRENT: calc_nxt = CALC_POWER;
            CALC_POWER: calc_nxt = (new_result || calc_again_r) ? CALC_CURRENT : CALC_IDLE;
            default: calc_nxt = CALC_IDLE;
        endcase
    end

    // A fresh result sets ready; that set wins over a status read
    assign ready_nxt = (calc_r == CALC_POWER) || (ready_r && !stat_rd);

    ////////////////////////////////////////////////////////////////////////
    // Configuration, calibration and status
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_r <= CFG_RESET;
            cal_r <= CAL_RESET;
            ready_r <= 1'b0;
            calc_r <= CALC_IDLE;
            calc_again_r <= 1'b0;
            ctrl_r <= '{request: 1'b1, shunt_en: 1'b1, bus_en: 1'b1, continuous: 1'b1};
        end
        else
        begin
            cfg_r <= cfg_nxt;
            cal_r <= cal_nxt;
            ready_r <= ready_nxt;
            calc_r <= calc_nxt;
            calc_again_r <= (calc_r == CALC_CURRENT) && new_result;
            ctrl_r <= ctrl_nxt;
        end
    end

    // Which measurements of a triggered run have completed
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            shunt_got_r <= 1'b0;
            bus_got_r <= 1'b0;
        end
        else
        begin
            shunt_got_r <= (cfg_wr || trig_done) ? 1'b0 : (shunt_got_r || shunt_avg_valid);
            bus_got_r <= (cfg_wr || trig_done) ? 1'b0 : (bus_got_r || bus_avg_valid);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Measurement results; each word is replaced whole at one edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            shunt_r <= RESULT_RESET;
            bus_r <= RESULT_RESET;
        end
        else
        begin
            if (shunt_avg_valid)
                shunt_r <= shunt_avg;
            if (bus_avg_valid)
                bus_r <= bus_avg & BUS_MAG_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            current_r <= RESULT_RESET;
            power_r <= RESULT_RESET;
        end
        else
        begin
            if (calc_r == CALC_CURRENT)
                current_r <= calc_current(shunt_r, cal_r);
            if (calc_r == CALC_POWER)
                power_r <= calc_power(current_r, bus_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus slave state; zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= IDX_CONFIG;
            hrdata_r <= 32'h00000000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
        else
        begin
            // Writes to unmapped or misaligned addresses are dropped here
            wr_pend_r <= accept && hwrite && a_mapped;
            wr_idx_r <= a_idx;
            hrdata_r <= rd_accept ? rd_word : 32'h00000000;
            hreadyout_r <= 1'b1;
            hresp_r <= HRESP_OKAY[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign hrdata = hrdata_r;
    assign conv_ctrl = ctrl_r;

endmodule

// ==== verification/pmr_result_regs_sva.sv ====
`timescale 1ns/1ns
module pmr_result_regs_sva
    import pmr_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Converter side
    input wire pmr_conv_ctrl_t conv_ctrl
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic wr_ap_r;
    logic [5:0] idx_ap_r;
    logic [15:0] cfg_r;
    logic [15:0] cal_r;
    wire taken = hsel && hready && htrans[1];
    // Shadow copies of the writable registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ap_r <= 1'h0;
            idx_ap_r <= 6'h0;
            cfg_r <= CFG_RESET;
            cal_r <= CAL_RESET;
        end
        else
        begin
            wr_ap_r <= taken && hwrite;
            idx_ap_r <= haddr[IDX_MSB:IDX_LSB];
            if (wr_ap_r && idx_ap_r == IDX_CONFIG)
                cfg_r <= hwdata[15:0] & CFG_WR_MASK;
            if (wr_ap_r && idx_ap_r == IDX_CAL)
                cal_r <= hwdata[15:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_read(logic [5:0] idx);
        taken && !hwrite && haddr[IDX_MSB:IDX_LSB] == idx;
    endsequence
    sequence s_cont_held;
        (cfg_r[MODE_CONT_BIT] && cfg_r[1:0] != 2'h0 && $stable(cfg_r))[*3];
    endsequence
    a_resp_okay: assert property (!hresp) else $error("response not okay");
    a_ready_high: assert property (hreadyout) else $error("wait state inserted");
    a_idle_rdata: assert property (!(taken && !hwrite) |=> hrdata == 32'h0)
        else $error("read data without read");
    a_bus_top_zero: assert property (s_read(IDX_BUS) |=> !hrdata[15])
        else $error("bus result top bit set");
    a_cal_readback: assert property (s_read(IDX_CAL) |=> hrdata == {16'h0, cal_r})
        else $error("calibration readback wrong");
    a_cfg_readback: assert property (s_read(IDX_CONFIG) |=> hrdata == {16'h0, cfg_r})
        else $error("config readback wrong");
    a_mode_levels: assert property ($stable(cfg_r) |->
        {conv_ctrl.continuous, conv_ctrl.bus_en, conv_ctrl.shunt_en}
        == {cfg_r[MODE_CONT_BIT] && cfg_r[1:0] != 2'h0, cfg_r[1:0]})
        else $error("mode decode wrong");
    a_pdown_idle: assert property (cfg_r[1:0] == 2'h0 && $stable(cfg_r) |->
        !conv_ctrl.request) else $error("request in power-down");
    a_cont_running: assert property (s_cont_held |-> conv_ctrl.request)
        else $error("continuous mode stopped");
endmodule

bind pmr_result_regs pmr_result_regs_sva chk_u
(
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .conv_ctrl(conv_ctrl)
);

// ==== verification/pmr_conv_model.sv ====
`timescale 1ns/1ns
module pmr_conv_model
    import pmr_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench controls
    input wire logic go,
    input wire logic slow,
    input wire logic [15:0] shunt_code,
    input wire logic [15:0] bus_code,
    // Converter interface
    input wire pmr_conv_ctrl_t conv_ctrl,
    output pmr_sample_t sample
);
    logic turn_r;
    logic [1:0] gap_r;
    wire fire = go && conv_ctrl.request && gap_r == 2'h0;
    wire pick_bus = conv_ctrl.bus_en && (turn_r || !conv_ctrl.shunt_en);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sample <= '0;
            turn_r <= 1'h0;
            gap_r <= 2'h0;
        end
        else
        begin
            gap_r <= slow ? gap_r + 2'h1 : 2'h0;
            turn_r <= fire ? !turn_r : turn_r;
            sample.valid <= fire && (conv_ctrl.shunt_en || conv_ctrl.bus_en);
            sample.is_bus <= pick_bus;
            // Data is scrambled outside a valid pulse
            sample.data <= fire ? (pick_bus ? bus_code : shunt_code) : ~sample.data;
        end
    end
endmodule

// ==== verification/tb_power_monitor_result_regs.sv ====
`timescale 1ns/1ns
module tb_power_monitor_result_regs;
    import pmr_pkg::*;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = HTRANS_IDLE;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    pmr_sample_t sample;
    pmr_conv_ctrl_t conv_ctrl;
    logic go = 1'h0;
    logic slow = 1'h0;
    logic [15:0] shunt_code = 16'h0;
    logic [15:0] bus_code = 16'h0;
    int error_cnt = 0;
    int checked = 0;

    always #25 hclk = ~hclk;
    assign hready = hreadyout;

    pmr_result_regs dut_u
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample(sample),
        .conv_ctrl(conv_ctrl)
    );
    pmr_conv_model far_u
    (
        .hclk(hclk), .hresetn(hresetn), .go(go), .slow(slow), .shunt_code(shunt_code),
        .bus_code(bus_code), .conv_ctrl(conv_ctrl), .sample(sample)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Waits for hready high at a rising edge; the watchdog ends a hang
    task automatic wait_ready(output logic [31:0] rd);
        @(posedge hclk);
        while (hready !== 1'h1)
            @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic bus_xfer(input logic wr, input logic [5:0] idx, input logic [15:0] wd,
        output logic [31:0] rd);
        logic [31:0] unused;
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, idx, 2'h0};
        wait_ready(unused);
        hsel <= 1'h0;
        htrans <= HTRANS_IDLE;
        hwdata <= {16'h0, wd};
        wait_ready(rd);
    endtask

    task automatic reg_write(input logic [5:0] idx, input logic [15:0] wd);
        logic [31:0] unused;
        bus_xfer(1'h1, idx, wd, unused);
    endtask

    task automatic reg_check(input logic [5:0] idx, input logic [15:0] exp);
        logic [31:0] rd;
        bus_xfer(1'h0, idx, 16'h0, rd);
        compare(rd, {16'h0, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        compare(32'(conv_ctrl), 32'hF);
        reg_check(IDX_CONFIG, CFG_RESET);
        reg_check(IDX_CAL, CAL_RESET);
        for (int i = 1; i <= 4; i++)
            reg_check(6'(i), RESULT_RESET);
        reg_check(6'h20, 16'h0);
    endtask

    task automatic t_results();
        logic [15:0] codes [2] = '{16'h8300, 16'h0100};
        int cur;
        int pwr;
        reg_write(IDX_CAL, 16'h0400);
        reg_check(IDX_CAL, 16'h0400);
        for (int k = 0; k < 2; k++)
        begin
            shunt_code <= codes[k];
            bus_code <= 16'hC000;
            slow <= k[0];
            go <= 1'h1;
            reg_write(IDX_SHUNT, 16'h1234);
            repeat (40) @(posedge hclk);
            cur = (int'(signed'(codes[k])) * 1024) >>> CURRENT_SHIFT;
            pwr = (cur < 0 ? -cur : cur) * int'(16'hC000 & BUS_MAG_MASK) / int'(POWER_DIV);
            reg_check(IDX_SHUNT, codes[k]);
            reg_check(IDX_BUS, 16'hC000 & BUS_MAG_MASK);
            reg_check(IDX_CURRENT, 16'(cur));
            reg_check(IDX_POWER, 16'(pwr));
        end
    endtask

    task automatic t_modes();
        logic [2:0] m;
        for (int i = 0; i < 8; i++)
        begin
            m = 3'(i);
            reg_write(IDX_CONFIG, {13'h0, m});
            repeat (40) @(posedge hclk);
            compare(32'(conv_ctrl), {28'h0, m[2] && m[1:0] != 2'h0, m[0], m[1],
                m[2] && m[1:0] != 2'h0});
            reg_check(IDX_CONFIG, {13'h0, m});
        end
    endtask

    // Triggered shunt run over 16 averages at one sample every 4 cycles
    task automatic t_average();
        shunt_code <= 16'h8300;
        slow <= 1'h1;
        reg_write(IDX_CONFIG, 16'h0401);
        reg_check(IDX_CONFIG, 16'h0401);
        repeat (40) @(posedge hclk);
        compare(32'(conv_ctrl.request), 32'h1);
        repeat (40) @(posedge hclk);
        compare(32'(conv_ctrl.request), 32'h0);
        reg_check(IDX_SHUNT, 16'h8300);
        reg_check(IDX_STATUS, 16'h0001);
        reg_check(IDX_STATUS, 16'h0000);
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        t_reset_values();
        t_results();
        t_modes();
        t_average();
        end_of_test();
    end

    // Whole run needs under 1500 cycles
    initial
    begin
        repeat (4000) @(posedge hclk);
        error_cnt++;
        end_of_test();
    end
endmodule
